//--- inc/fmr_pkg.sv
/*
  Constants for the float-mode and status register bank: offsets, field
  positions, reset values and encodings.
  Assumes a 16-bit register space with 8-bit addresses behind the serial port.
*/
package fmr_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h01;
  localparam logic [7:0] OFS_FLOAT_B = 8'h59;
  localparam logic [7:0] OFS_FIRE_MASK = 8'h5A;
  localparam logic [7:0] OFS_FLOAT_A = 8'h5E;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_IRQ_MASK = 16'h01FF;
  localparam logic [15:0] RST_FLOAT_B = 16'h0808;
  localparam logic [15:0] RST_FIRE_MASK = 16'h0010;
  localparam logic [15:0] RST_FLOAT_A = 16'h0808;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int FLT_EN_LSB = 13;
  localparam int FLT_EN_MSB = 14;
  localparam int PRECON_LSB = 8;
  localparam int PRECON_MSB = 12;
  localparam int FIRE_A_LSB = 8;
  localparam int FIRE_A_MSB = 11;
  localparam int FIRE_B_LSB = 12;
  localparam int FIRE_B_MSB = 15;
  localparam int CNT_LSB = 8;
  localparam int CNT_MSB = 15;
  localparam int FIFO_CLR_BIT = 15;
  localparam int RSVD_HI_BIT = 7;
  localparam int SLOT_B_BIT = 6;
  localparam int SLOT_A_BIT = 5;
  localparam int RSVD_LO_MSB = 4;
  localparam int FIFO_MASK_BIT = 8;
  localparam int SLOT_B_MASK_BIT = 6;
  localparam int SLOT_A_MASK_BIT = 5;

  // ----------------------------------------------------------------------
  // encodings and timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] FLT_EN_OFF = 2'h0;
  localparam logic [1:0] FLT_EN_ON = 2'h3;
  localparam logic [4:0] RSVD_LO_CLR = 5'h1F;
  // typical preconditioning time reached by the reset code
  localparam int PRECON_TYPICAL_NS = 16000;

endpackage

//--- rtl/fmr_flag.sv
/*
  One sticky status flag: set by a hardware event, cleared by software.
  Assumes set and clear are one-cycle strobes in the core clock domain.
*/
module fmr_flag
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic set_in,
  input wire logic clr_in,
  // state
  output logic flag_out
);

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      flag_out <= 1'b0;
    end
    else if (set_in)
    begin
      flag_out <= 1'b1;
    end
    else if (clr_in)
    begin
      flag_out <= 1'b0;
    end
  end

endmodule

//--- rtl/fmr_regs.sv
/*
  Float-mode configuration, LED pulse fire masks, FIFO status and the
  sample interrupt flags with their masks.
  Assumes the serial port front end delivers single-cycle register read
  and write strobes with an 8-bit address and 16-bit data, all synchronous
  to core_clk_in.
*/
//
// Overview of operation
// - slot A float only when enable is 3
// - slot B float enable uses same encoding
// - slot A preconditioning field, reset 0x08
// - slot B preconditioning field, reset 0x08
// - slot B fire mask bits 12-15
// - slot A fire mask bits 8-11
// - status upper byte shows FIFO byte count
// - write 1 to bit 15 clears FIFO
// - slot B flag set by event, W1C
// - slot A flag set by event, W1C
// - reserved bit 7 cleared by writing 1
// - reserved bits 4:0 cleared by 0x1F
// - FIFO mask resets 1, 0 enables interrupt
// - slot sample masks reset 1, suppress
module fmr_regs
#(
  parameter int THRESH_W = 6
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // events and fifo state
  input wire logic slot_a_sample_evt_in,
  input wire logic slot_b_sample_evt_in,
  input wire logic [5:0] rsvd_status_evt_in,
  input wire logic [7:0] fifo_byte_count_in,
  input wire logic [THRESH_W-1:0] fifo_thresh_words_in,
  // controls to the sampling engine
  output logic float_active_a_out,
  output logic float_active_b_out,
  output logic [4:0] float_precondition_time_a_out,
  output logic [4:0] float_precondition_time_b_out,
  output logic [3:0] pulse_fire_mask_a_out,
  output logic [3:0] pulse_fire_mask_b_out,
  output logic fifo_clear_out,
  output logic irq_out
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [15:0] float_config_slot_a_r;
  logic [15:0] float_config_slot_b_r;
  logic [15:0] led_pulse_fire_mask_r;
  logic [15:0] irq_mask_control_r;
  logic [7:0] flags;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic wr_status;
  logic fifo_over;
  logic irq_nxt;
  logic [15:0] rdata_nxt;
  logic [THRESH_W:0] thresh_bytes;

  assign wr_status = reg_wr_in && (reg_addr_in == fmr_pkg::OFS_STATUS);

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  // precondition fields reset to 0x08 with the rest
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      float_config_slot_a_r <= fmr_pkg::RST_FLOAT_A;
      float_config_slot_b_r <= fmr_pkg::RST_FLOAT_B;
      led_pulse_fire_mask_r <= fmr_pkg::RST_FIRE_MASK;
      irq_mask_control_r <= fmr_pkg::RST_IRQ_MASK;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == fmr_pkg::OFS_FLOAT_A)
      begin
        float_config_slot_a_r <= reg_wdata_in;
      end
      else if (reg_addr_in == fmr_pkg::OFS_FLOAT_B)
      begin
        float_config_slot_b_r <= reg_wdata_in;
      end
      else if (reg_addr_in == fmr_pkg::OFS_FIRE_MASK)
      begin
        led_pulse_fire_mask_r <= reg_wdata_in;
      end
      else if (reg_addr_in == fmr_pkg::OFS_IRQ_MASK)
      begin
        irq_mask_control_r <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // controls to the sampling engine
  // ----------------------------------------------------------------------
  // reserved codes 1 and 2 leave float off
  assign float_active_a_out =
    float_config_slot_a_r[fmr_pkg::FLT_EN_MSB:fmr_pkg::FLT_EN_LSB] == fmr_pkg::FLT_EN_ON;
  assign float_active_b_out =
    float_config_slot_b_r[fmr_pkg::FLT_EN_MSB:fmr_pkg::FLT_EN_LSB] == fmr_pkg::FLT_EN_ON;
  assign float_precondition_time_a_out =
    float_config_slot_a_r[fmr_pkg::PRECON_MSB:fmr_pkg::PRECON_LSB];
  // slot B delay, independent of slot A
  assign float_precondition_time_b_out =
    float_config_slot_b_r[fmr_pkg::PRECON_MSB:fmr_pkg::PRECON_LSB];
  // bit 8 is first pulse, 1 suppresses
  assign pulse_fire_mask_a_out =
    led_pulse_fire_mask_r[fmr_pkg::FIRE_A_MSB:fmr_pkg::FIRE_A_LSB];
  // bit 12 is first pulse, 1 suppresses
  assign pulse_fire_mask_b_out =
    led_pulse_fire_mask_r[fmr_pkg::FIRE_B_MSB:fmr_pkg::FIRE_B_LSB];

  // one-cycle flush strobe; the count field itself is not stored
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      fifo_clear_out <= 1'b0;
    end
    else
    begin
      fifo_clear_out <= wr_status && reg_wdata_in[fmr_pkg::FIFO_CLR_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------------
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[fmr_pkg::RSVD_HI_BIT] = rsvd_status_evt_in[5];
    flag_set[fmr_pkg::SLOT_B_BIT] = slot_b_sample_evt_in;
    flag_set[fmr_pkg::SLOT_A_BIT] = slot_a_sample_evt_in;
    flag_set[fmr_pkg::RSVD_LO_MSB:0] = rsvd_status_evt_in[4:0];
    flag_clr = 8'h00;
    flag_clr[fmr_pkg::RSVD_HI_BIT] = wr_status && reg_wdata_in[fmr_pkg::RSVD_HI_BIT];
    flag_clr[fmr_pkg::SLOT_B_BIT] = wr_status && reg_wdata_in[fmr_pkg::SLOT_B_BIT];
    flag_clr[fmr_pkg::SLOT_A_BIT] = wr_status && reg_wdata_in[fmr_pkg::SLOT_A_BIT];
    // low reserved field clears only on 0x1F
    flag_clr[fmr_pkg::RSVD_LO_MSB:0] = {5{wr_status &&
      (reg_wdata_in[fmr_pkg::RSVD_LO_MSB:0] == fmr_pkg::RSVD_LO_CLR)}};
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      fmr_flag u_flag
      (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(flag_set[gi]),
        .clr_in(flag_clr[gi]),
        .flag_out(flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------------
  // threshold is in two-byte words, the count in bytes
  assign thresh_bytes = {fifo_thresh_words_in, 1'b0};
  // compared as int so neither side is cut whatever THRESH_W is
  assign fifo_over = int'(fifo_byte_count_in) > int'(thresh_bytes);

  always_comb
  begin
    irq_nxt = 1'b0;
    // fifo level interrupt when its mask is 0
    if (fifo_over && !irq_mask_control_r[fmr_pkg::FIFO_MASK_BIT])
    begin
      irq_nxt = 1'b1;
    end
    // slot masks at 1 suppress the flags
    if (flags[fmr_pkg::SLOT_A_BIT] && !irq_mask_control_r[fmr_pkg::SLOT_A_MASK_BIT])
    begin
      irq_nxt = 1'b1;
    end
    if (flags[fmr_pkg::SLOT_B_BIT] && !irq_mask_control_r[fmr_pkg::SLOT_B_MASK_BIT])
    begin
      irq_nxt = 1'b1;
    end
  end

  // registered level, drops once no unmasked cause remains
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (reg_addr_in == fmr_pkg::OFS_STATUS)
    begin
      // live FIFO byte count in the upper byte
      rdata_nxt = {fifo_byte_count_in, flags};
    end
    else if (reg_addr_in == fmr_pkg::OFS_IRQ_MASK)
    begin
      rdata_nxt = irq_mask_control_r;
    end
    else if (reg_addr_in == fmr_pkg::OFS_FLOAT_B)
    begin
      rdata_nxt = float_config_slot_b_r;
    end
    else if (reg_addr_in == fmr_pkg::OFS_FIRE_MASK)
    begin
      rdata_nxt = led_pulse_fire_mask_r;
    end
    else if (reg_addr_in == fmr_pkg::OFS_FLOAT_A)
    begin
      rdata_nxt = float_config_slot_a_r;
    end
  end

  // unmapped addresses read as zero; data holds until the next read
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      reg_rdata_out <= 16'h0000;
    end
    else if (reg_rd_in)
    begin
      reg_rdata_out <= rdata_nxt;
    end
  end

endmodule

//--- dv/fmr_regs_assertions.sv
/*
  Port checker for fmr_regs: config writes, fifo clear pulse, irq timing.
  Assumes bind to fmr_regs; mask register is tracked from port traffic.
*/
module fmr_regs_assertions
#(
  parameter int THRESH_W = 6
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  // events and fifo state
  input wire logic slot_a_sample_evt_in,
  input wire logic [7:0] fifo_byte_count_in,
  input wire logic [THRESH_W-1:0] fifo_thresh_words_in,
  // outputs watched
  input wire logic float_active_a_out,
  input wire logic float_active_b_out,
  input wire logic [4:0] float_precondition_time_a_out,
  input wire logic [3:0] pulse_fire_mask_a_out,
  input wire logic [3:0] pulse_fire_mask_b_out,
  input wire logic fifo_clear_out,
  input wire logic irq_out
);
  logic [15:0] mask_r;
  logic [15:0] wd_r;
  logic [7:0] wa_r;
  logic [7:0] lim;
  assign lim = {1'b0, fifo_thresh_words_in, 1'b0};
  // wa_r holds an address no register uses when no write was taken
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mask_r <= fmr_pkg::RST_IRQ_MASK;
      wd_r <= 16'h0000;
      wa_r <= 8'hFF;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == fmr_pkg::OFS_IRQ_MASK)
      begin
        mask_r <= reg_wdata_in;
      end
      wd_r <= reg_wdata_in;
      wa_r <= reg_wr_in ? reg_addr_in : 8'hFF;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence clr_pulse;
    fifo_clear_out ##1 !fifo_clear_out;
  endsequence
  float_en_a_a:
    assert property (wa_r == fmr_pkg::OFS_FLOAT_A |-> float_active_a_out == (wd_r[14:13] == 2'h3))
    else $error("slot a float enable wrong");
  float_en_b_a:
    assert property (wa_r == fmr_pkg::OFS_FLOAT_B |-> float_active_b_out == (wd_r[14:13] == 2'h3))
    else $error("slot b float enable wrong");
  precon_a_a:
    assert property (wa_r == fmr_pkg::OFS_FLOAT_A |-> float_precondition_time_a_out == wd_r[12:8])
    else $error("slot a precondition wrong");
  fire_masks_a:
    assert property (wa_r == fmr_pkg::OFS_FIRE_MASK
      |-> {pulse_fire_mask_b_out, pulse_fire_mask_a_out} == wd_r[15:8])
    else $error("fire masks wrong");
  fifo_clr_a:
    assert property (reg_wr_in && reg_addr_in == 8'h00 && reg_wdata_in[15] |=> clr_pulse)
    else $error("fifo clear pulse missing");
  clr_quiet_a:
    assert property (!(reg_wr_in && reg_addr_in == 8'h00 && reg_wdata_in[15]) |=> !fifo_clear_out)
    else $error("spurious fifo clear");
  slot_irq_a:
    assert property (slot_a_sample_evt_in && !mask_r[5] && !reg_wr_in |-> ##2 irq_out)
    else $error("slot a irq missing");
  masked_quiet_a:
    assert property (mask_r[8] && mask_r[6] && mask_r[5] |=> !irq_out)
    else $error("irq while all masked");
  fifo_irq_a:
    assert property (!mask_r[8] && fifo_byte_count_in > lim |=> irq_out)
    else $error("fifo irq missing");
endmodule

bind fmr_regs fmr_regs_assertions #(.THRESH_W(THRESH_W)) u_chk (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
  .slot_a_sample_evt_in(slot_a_sample_evt_in), .fifo_byte_count_in(fifo_byte_count_in),
  .fifo_thresh_words_in(fifo_thresh_words_in), .float_active_a_out(float_active_a_out),
  .float_active_b_out(float_active_b_out),
  .float_precondition_time_a_out(float_precondition_time_a_out),
  .pulse_fire_mask_a_out(pulse_fire_mask_a_out), .pulse_fire_mask_b_out(pulse_fire_mask_b_out),
  .fifo_clear_out(fifo_clear_out), .irq_out(irq_out));

//--- dv/fmr_host.sv
/*
  Host model: single-cycle register read and write strobes.
  Assumes one access at a time, launched just after a rising edge.
*/
module fmr_host
(
  // clock
  input wire logic core_clk_in,
  // register port
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [15:0] reg_wdata_out,
  output logic reg_rd_out,
  input wire logic [15:0] reg_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_addr_out = 8'hFF;
    reg_wr_out = 1'b0;
    reg_wdata_out = 16'h0000;
    reg_rd_out = 1'b0;
  end
  // idle bus shows inverted values so stale data never passes for valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge core_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    #1;
    q = reg_rdata_in;
  endtask
endmodule

//--- dv/tb_top.sv
/*
  Self-checking bench for fmr_regs.
  Assumes the host model drives the register port; events come from here.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [7:0] evts = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic [5:0] thr = 6'h04;
  logic fa, fb, fclr, irq;
  logic [4:0] pa, pb;
  logic [3:0] ma, mb;
  int miscompares = 0;
  int checks_done = 0;
  always #2.5 core_clk_in = ~core_clk_in;
  fmr_host host (.core_clk_in(core_clk_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_wdata_out(wdata), .reg_rd_out(rd), .reg_rdata_in(rdata));
  fmr_regs dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .slot_a_sample_evt_in(evts[6]), .slot_b_sample_evt_in(evts[7]),
    .rsvd_status_evt_in(evts[5:0]), .fifo_byte_count_in(cnt), .fifo_thresh_words_in(thr),
    .float_active_a_out(fa), .float_active_b_out(fb), .float_precondition_time_a_out(pa),
    .float_precondition_time_b_out(pb), .pulse_fire_mask_a_out(ma),
    .pulse_fire_mask_b_out(mb), .fifo_clear_out(fclr), .irq_out(irq));
  // ------------
  // helpers
  // ------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    host.rd(a, q);
    chk("rdata", exp, q);
  endtask
  task automatic ev(input logic [7:0] v);
    @(posedge core_clk_in);
    evts <= v;
    @(posedge core_clk_in);
    evts <= 8'h00;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------
  // scenarios
  // ------------
  task automatic s_reset;
    chk("precon", 16'h0808, {3'h0, pa, 3'h0, pb});
    rchk(fmr_pkg::OFS_IRQ_MASK, 16'h01FF);
    rchk(fmr_pkg::OFS_FLOAT_A, 16'h0808);
    rchk(fmr_pkg::OFS_FLOAT_B, 16'h0808);
    rchk(fmr_pkg::OFS_FIRE_MASK, 16'h0010);
    rchk(8'h33, 16'h0000);
  endtask
  task automatic s_float;
    for (int c = 0; c < 4; c++)
    begin
      host.wr(fmr_pkg::OFS_FLOAT_A, {1'b0, c[1:0], 5'h15, 8'h08});
      host.wr(fmr_pkg::OFS_FLOAT_B, {1'b0, c[1:0], 5'h0A, 8'h08});
      chk("float_a", {15'h0, c == 3}, {15'h0, fa});
      chk("float_b", {15'h0, c == 3}, {15'h0, fb});
      chk("precon", 16'h150A, {3'h0, pa, 3'h0, pb});
    end
  endtask
  task automatic s_fire;
    host.wr(fmr_pkg::OFS_FIRE_MASK, 16'h5A10);
    chk("fire", 16'h005A, {8'h00, mb, ma});
  endtask
  task automatic s_status;
    @(posedge core_clk_in);
    cnt <= 8'hA4;
    ev(8'hFF);
    rchk(8'h00, 16'hA4FF);
    host.wr(8'h00, 16'h0000);
    rchk(8'h00, 16'hA4FF);
    host.wr(8'h00, 16'h0040);
    rchk(8'h00, 16'hA4BF);
    host.wr(8'h00, 16'h0080);
    rchk(8'h00, 16'hA43F);
    host.wr(8'h00, 16'h000E);
    rchk(8'h00, 16'hA43F);
    host.wr(8'h00, 16'h001F);
    rchk(8'h00, 16'hA420);
    host.wr(8'h00, 16'h8020);
    chk("fifo_clear", 16'h0001, {15'h0, fclr});
    rchk(8'h00, 16'hA400);
  endtask
  task automatic s_irq;
    @(posedge core_clk_in);
    cnt <= 8'h08;
    host.wr(fmr_pkg::OFS_IRQ_MASK, 16'h019F);
    ev(8'h40);
    @(posedge core_clk_in);
    #1;
    chk("irq", 16'h0001, {15'h0, irq});
    host.wr(8'h00, 16'h0020);
    @(posedge core_clk_in);
    #1;
    chk("irq", 16'h0000, {15'h0, irq});
    ev(8'h80);
    @(posedge core_clk_in);
    #1;
    chk("irq", 16'h0001, {15'h0, irq});
    host.wr(8'h00, 16'h0040);
    host.wr(fmr_pkg::OFS_IRQ_MASK, 16'h00FF);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk("irq", 16'h0000, {15'h0, irq});
    @(posedge core_clk_in);
    cnt <= 8'h09;
    @(posedge core_clk_in);
    #1;
    chk("irq", 16'h0001, {15'h0, irq});
    // raising the word threshold to 10 bytes takes the level cause away
    @(posedge core_clk_in);
    thr <= 6'h05;
    @(posedge core_clk_in);
    #1;
    chk("irq", 16'h0000, {15'h0, irq});
  endtask
  // ------------
  // main sequence
  // ------------
  initial
  begin
    repeat (10) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    s_reset();
    s_float();
    s_fire();
    s_status();
    s_irq();
    close_out();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    miscompares++;
    close_out();
  end
endmodule
